// ### src/misc_control_and_output9_current_code.sv
// Serial-bus register bank: misc control and ninth output current setting
`timescale 1ns/1ps
module misc_control_and_output9_current_code #(
   parameter int INT_DIV_CYCLES = led_ctrl_pkg::INT_DIV_CYCLES,
   parameter int EXT_LOSS_CYCLES = led_ctrl_pkg::EXT_LOSS_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Serial bus (open drain data)
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic [1:0] addr_sel_in,
   // External clock pin
   input wire logic ext_clk_in,
   // Control outputs
   output logic [7:0] output9_current_code_out,
   output logic variable_d_from_adc_out,
   output logic address_autoinc_enable_out,
   output logic power_save_enable_out,
   output logic [1:0] pump_gain_select_out,
   output logic pulse_width_low_power_enable_out,
   output logic [1:0] clk_sel_out,
   // Timing outputs
   output logic engine_tick_out,
   output logic ext_timing_in_use_flag_out
);

   typedef struct packed {
      led_ctrl_pkg::bus_state_e st;
      led_ctrl_pkg::bus_state_e ret;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic [7:0] ptr;
      logic scl_p;
      logic sda_p;
      logic oe;
      logic [7:0] misc;
      logic [7:0] led9;
   } bank_s;

   bank_s s_q;
   bank_s s_d;
   logic ext_in_use;

   if (INT_DIV_CYCLES < 2) begin : g_check
      $error("misc_control_and_output9_current_code: INT_DIV_CYCLES must be at least 2");
   end

   // Read data for a register pointer; unmapped addresses read zero
   function automatic logic [7:0] read_reg(input logic [7:0] ptr, input logic [7:0] misc,
                                           input logic [7:0] led9, input logic ext_used);
      logic [7:0] r;
      r = 8'h00;
      unique case (ptr)
         led_ctrl_pkg::MISC_CONTROL_OFS: r = misc;
         led_ctrl_pkg::OUTPUT9_CURRENT_OFS: r = led9;
         // Flag only means something while detection is enabled
         led_ctrl_pkg::STATUS_OFS:
            r[led_ctrl_pkg::EXT_IN_USE_BIT] = ext_used
               && misc[led_ctrl_pkg::DETECT_EN_BIT];
         default: r = 8'h00;
      endcase
      return r;
   endfunction : read_reg

   // Pointer step after a data byte; held still when auto-increment is off
   function automatic logic [7:0] next_ptr(input logic [7:0] ptr, input logic [7:0] misc);
      return misc[led_ctrl_pkg::AUTOINC_BIT] ? ptr + 8'h01 : ptr;
   endfunction : next_ptr

   // Slave protocol and register writes
   always_comb begin
      logic rise;
      logic fall;
      logic start;
      logic stop;
      logic [7:0] rd;
      rise = scl_in && !s_q.scl_p;
      fall = !scl_in && s_q.scl_p;
      start = scl_in && s_q.scl_p && s_q.sda_p && !sda_in;
      stop = scl_in && s_q.scl_p && !s_q.sda_p && sda_in;
      rd = read_reg(s_q.ptr, s_q.misc, s_q.led9, ext_in_use);
      s_d = s_q;
      s_d.scl_p = scl_in;
      s_d.sda_p = sda_in;
      if (start) begin
         // Repeated start keeps the pointer for a following read
         s_d.st = led_ctrl_pkg::ST_DEVADDR;
         s_d.cnt = 4'h0;
         s_d.oe = 1'b0;
      end else if (stop) begin
         s_d.st = led_ctrl_pkg::ST_IDLE;
         s_d.oe = 1'b0;
      end else begin
         unique case (s_q.st)
            led_ctrl_pkg::ST_IDLE: begin
               s_d.oe = 1'b0;
            end
            led_ctrl_pkg::ST_DEVADDR,
            led_ctrl_pkg::ST_REGADDR,
            led_ctrl_pkg::ST_WDATA: begin
               if (rise) begin
                  s_d.sh = {s_q.sh[6:0], sda_in};
                  s_d.cnt = s_q.cnt + 4'h1;
               end else if (fall && s_q.cnt == 4'h8) begin
                  s_d.oe = 1'b1;
                  s_d.st = led_ctrl_pkg::ST_ACK;
                  s_d.ret = led_ctrl_pkg::ST_WDATA;
                  if (s_q.st == led_ctrl_pkg::ST_DEVADDR) begin
                     // Other addresses are left alone and not acknowledged
                     if (s_q.sh[7:1] != {led_ctrl_pkg::DEV_ADDR_BASE[6:2], addr_sel_in}) begin
                        s_d.oe = 1'b0;
                        s_d.st = led_ctrl_pkg::ST_IDLE;
                     end else if (s_q.sh[0]) begin
                        s_d.ret = led_ctrl_pkg::ST_RDATA;
                     end else begin
                        s_d.ret = led_ctrl_pkg::ST_REGADDR;
                     end
                  end else if (s_q.st == led_ctrl_pkg::ST_REGADDR) begin
                     s_d.ptr = s_q.sh;
                  end else begin
                     if (s_q.ptr == led_ctrl_pkg::MISC_CONTROL_OFS) begin
                        s_d.misc = s_q.sh;
                     end
                     if (s_q.ptr == led_ctrl_pkg::OUTPUT9_CURRENT_OFS) begin
                        s_d.led9 = s_q.sh;
                     end
                     s_d.ptr = next_ptr(s_q.ptr, s_q.misc);
                  end
               end
            end
            led_ctrl_pkg::ST_ACK: begin
               if (fall) begin
                  s_d.cnt = 4'h0;
                  s_d.st = s_q.ret;
                  s_d.oe = 1'b0;
                  if (s_q.ret == led_ctrl_pkg::ST_RDATA) begin
                     s_d.sh = rd;
                     s_d.oe = !rd[7];
                  end
               end
            end
            led_ctrl_pkg::ST_RDATA: begin
               if (fall) begin
                  s_d.cnt = s_q.cnt + 4'h1;
                  s_d.sh = {s_q.sh[6:0], 1'b0};
                  s_d.oe = !s_q.sh[6];
                  if (s_q.cnt == 4'h7) begin
                     // Release for the master's acknowledge
                     s_d.oe = 1'b0;
                     s_d.st = led_ctrl_pkg::ST_RACK;
                     s_d.ptr = next_ptr(s_q.ptr, s_q.misc);
                  end
               end
            end
            led_ctrl_pkg::ST_RACK: begin
               if (rise && sda_in) begin
                  // Not acknowledged: master ends the read
                  s_d.st = led_ctrl_pkg::ST_IDLE;
               end else if (fall) begin
                  s_d.cnt = 4'h0;
                  s_d.sh = rd;
                  s_d.oe = !rd[7];
                  s_d.st = led_ctrl_pkg::ST_RDATA;
               end
            end
            default: begin
               s_d.st = led_ctrl_pkg::ST_IDLE;
               s_d.oe = 1'b0;
            end
         endcase
      end
   end

   // State register; control fields take their documented reset values
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         s_q <= '0;
         s_q.st <= led_ctrl_pkg::ST_IDLE;
         s_q.ret <= led_ctrl_pkg::ST_IDLE;
         s_q.scl_p <= 1'b1;
         s_q.sda_p <= 1'b1;
         s_q.misc <= led_ctrl_pkg::MISC_CONTROL_RESET;
         s_q.led9 <= led_ctrl_pkg::OUTPUT9_CURRENT_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Clock source selection and detection
   engine_timing_select #(
      .INT_DIV_CYCLES(INT_DIV_CYCLES),
      .EXT_LOSS_CYCLES(EXT_LOSS_CYCLES)
   ) u_timing (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .ext_clk_in(ext_clk_in),
      .clk_sel_in(s_q.misc[led_ctrl_pkg::DETECT_EN_BIT:led_ctrl_pkg::INT_EN_BIT]),
      .engine_tick_out(engine_tick_out),
      .ext_in_use_out(ext_in_use)
   );

   // Open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe_out = s_q.oe;

   // Field outputs straight from the stored registers; the timing selector's in-use flag is gated by detect enable
   assign output9_current_code_out = s_q.led9;
   assign variable_d_from_adc_out = s_q.misc[led_ctrl_pkg::VAR_D_SEL_BIT];
   assign address_autoinc_enable_out = s_q.misc[led_ctrl_pkg::AUTOINC_BIT];
   assign power_save_enable_out = s_q.misc[led_ctrl_pkg::POWER_SAVE_BIT];
   assign pump_gain_select_out = s_q.misc[led_ctrl_pkg::PUMP_GAIN_LSB +: 2];
   // Passed on unchecked; keeping it clear above 1x pump is software's job
   assign pulse_width_low_power_enable_out = s_q.misc[led_ctrl_pkg::PWM_LOW_POWER_BIT];
   assign clk_sel_out = s_q.misc[led_ctrl_pkg::DETECT_EN_BIT:led_ctrl_pkg::INT_EN_BIT];
   assign ext_timing_in_use_flag_out = ext_in_use && s_q.misc[led_ctrl_pkg::DETECT_EN_BIT];

endmodule : misc_control_and_output9_current_code

// ### src/led_ctrl_pkg.sv
// Constants shared by the control register bank and its timing selector
package led_ctrl_pkg;

   // Register offsets on the serial bus
   localparam logic [7:0] MISC_CONTROL_OFS = 8'h05;
   localparam logic [7:0] OUTPUT9_CURRENT_OFS = 8'h2E;
   localparam logic [7:0] STATUS_OFS = 8'h3A;

   // Field positions in misc_control
   localparam int VAR_D_SEL_BIT = 7;
   localparam int AUTOINC_BIT = 6;
   localparam int POWER_SAVE_BIT = 5;
   localparam int PUMP_GAIN_LSB = 3;
   localparam int PWM_LOW_POWER_BIT = 2;
   localparam int DETECT_EN_BIT = 1;
   localparam int INT_EN_BIT = 0;
   // Position of the external-timing flag in the status register
   localparam int EXT_IN_USE_BIT = 0;

   // Values after reset
   localparam logic [7:0] MISC_CONTROL_RESET = 8'h40;
   localparam logic [7:0] OUTPUT9_CURRENT_RESET = 8'hAF;

   // Serial-bus device address; low two bits come from the select pins
   localparam logic [6:0] DEV_ADDR_BASE = 7'h34;

   // Timing: system clock and nominal internal oscillator (tenths of Hz)
   localparam longint CLK_HZ = 64'd250000000;
   localparam longint INT_OSC_DECI_HZ = 64'd327;
   localparam int INT_DIV_CYCLES = int'((CLK_HZ * 64'd10) / INT_OSC_DECI_HZ);
   // External clock is declared lost after this many nominal periods without an edge
   localparam int EXT_LOSS_PERIODS = 4;
   localparam int EXT_LOSS_CYCLES = INT_DIV_CYCLES * EXT_LOSS_PERIODS;

   // Clock selection codes {detect enable, internal enable}
   typedef enum logic [1:0] {
      CLK_FORCED_EXT = 2'h0,
      CLK_FORCED_INT = 2'h1,
      CLK_AUTO = 2'h2,
      CLK_INTERNAL = 2'h3
   } clk_sel_e;

   // Serial-bus slave states
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_DEVADDR = 7'h02,
      ST_REGADDR = 7'h04,
      ST_WDATA = 7'h08,
      ST_ACK = 7'h10,
      ST_RDATA = 7'h20,
      ST_RACK = 7'h40
   } bus_state_e;

endpackage : led_ctrl_pkg

// ### src/engine_timing_select.sv
// Selects the clock that paces program execution and detects the external clock
`timescale 1ns/1ps
module engine_timing_select #(
   parameter int INT_DIV_CYCLES = led_ctrl_pkg::INT_DIV_CYCLES,
   parameter int EXT_LOSS_CYCLES = led_ctrl_pkg::EXT_LOSS_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Clock pin and selection
   input wire logic ext_clk_in,
   input wire logic [1:0] clk_sel_in,
   // Pacing and status
   output logic engine_tick_out,
   output logic ext_in_use_out
);

   localparam int DW = $clog2(INT_DIV_CYCLES + 1);
   localparam int LW = $clog2(EXT_LOSS_CYCLES + 1);

   typedef struct packed {
      logic [DW-1:0] div;
      logic [LW-1:0] loss;
      logic ext_p;
      logic present;
      logic tick;
      logic in_use;
   } timing_s;

   timing_s s_q;
   timing_s s_d;

   if (INT_DIV_CYCLES < 2 || EXT_LOSS_CYCLES < 2) begin : g_check
      $error("engine_timing_select: divider counts must be at least 2");
   end

   // Internal divider, edge detector with a loss timeout only: no upper
   // frequency bound, so any edge rate keeps the clock accepted
   always_comb begin
      logic ext_edge;
      logic int_tick;
      logic use_ext;
      use_ext = 1'b0;
      ext_edge = ext_clk_in && !s_q.ext_p;
      int_tick = (s_q.div == DW'(INT_DIV_CYCLES - 1));
      s_d = s_q;
      s_d.ext_p = ext_clk_in;
      s_d.div = int_tick ? '0 : s_q.div + DW'(1);
      if (ext_edge) begin
         s_d.loss = '0;
         s_d.present = 1'b1;
      end else if (s_q.loss == LW'(EXT_LOSS_CYCLES - 1)) begin
         s_d.present = 1'b0;
      end else begin
         s_d.loss = s_q.loss + LW'(1);
      end
      // Forced external follows the pin alone; auto needs a detected signal
      unique case (led_ctrl_pkg::clk_sel_e'(clk_sel_in))
         led_ctrl_pkg::CLK_FORCED_EXT: use_ext = 1'b1;
         led_ctrl_pkg::CLK_AUTO: use_ext = s_q.present;
         led_ctrl_pkg::CLK_FORCED_INT,
         led_ctrl_pkg::CLK_INTERNAL: use_ext = 1'b0;
      endcase
      // Engines step once per selected edge, so pace scales with it
      s_d.tick = use_ext ? ext_edge : int_tick;
      s_d.in_use = use_ext && s_q.present;
   end

   // State register
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign engine_tick_out = s_q.tick;
   assign ext_in_use_out = s_q.in_use;

endmodule : engine_timing_select

// ### verification/host_master.sv
// Behavioural serial-bus host that drives the register bank's bus pins
`timescale 1ns/1ps
module host_master (
   // Clock and wire level
   input wire logic clk_in,
   input wire logic sda_wire_in,
   // Bus drive
   output logic scl_out,
   output logic sda_low_out
);
   // Clocks per SCL phase; the bench may stretch it to act as a slow host
   int ph = 4;
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   task automatic hold();
      repeat (ph) @(posedge clk_in);
   endtask : hold
   // Data changes only while SCL is low, sampled at the end of SCL high
   task automatic bit_io(input logic b, output logic r);
      sda_low_out <= ~b;
      hold();
      scl_out <= 1'b1;
      hold();
      r = sda_wire_in;
      scl_out <= 1'b0;
      hold();
   endtask : bit_io
   // Also serves as repeated start, since SDA is released before SCL rises
   task automatic start_cond();
      sda_low_out <= 1'b0;
      hold();
      scl_out <= 1'b1;
      hold();
      sda_low_out <= 1'b1;
      hold();
      scl_out <= 1'b0;
      hold();
   endtask : start_cond
   task automatic stop_cond();
      sda_low_out <= 1'b1;
      hold();
      scl_out <= 1'b1;
      hold();
      sda_low_out <= 1'b0;
      hold();
   endtask : stop_cond
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask : put_byte
   // Writes n bytes (1 or 2) from ofs; ok is low if any byte went unanswered
   task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d0,
      input logic [7:0] d1, input int n, output logic ok);
      logic a;
      start_cond();
      put_byte({dev, 1'b0}, ok);
      if (ok) begin
         put_byte(ofs, a);
         ok = ok & a;
         put_byte(d0, a);
         ok = ok & a;
         if (n > 1) begin
            put_byte(d1, a);
            ok = ok & a;
         end
      end
      stop_cond();
   endtask : wr
   // Single byte read, ended with a NACK then stop
   task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] d);
      logic a;
      start_cond();
      put_byte({dev, 1'b0}, a);
      put_byte(ofs, a);
      start_cond();
      put_byte({dev, 1'b1}, a);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, a);
      stop_cond();
   endtask : rd
endmodule : host_master

// ### verification/misc_control_props.sv
// Concurrent checks on the register bank's ports
`timescale 1ns/1ps
module misc_control_props #(
   parameter int INT_DIV_CYCLES = 8,
   parameter int EXT_LOSS_CYCLES = 32
) (
   // Clock, reset and clock pin
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic ext_clk_in,
   // Register and timing outputs
   input wire logic [7:0] output9_current_code_out,
   input wire logic variable_d_from_adc_out,
   input wire logic address_autoinc_enable_out,
   input wire logic power_save_enable_out,
   input wire logic [1:0] pump_gain_select_out,
   input wire logic [1:0] clk_sel_out,
   input wire logic engine_tick_out,
   input wire logic ext_timing_in_use_flag_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // Pacing helpers: cycles since the last tick and since the last pin rise
   int gap;
   int quiet;
   logic int_q;
   logic steady;
   // A gap is judged only when the tick at each end was made on the internal clock,
   // since a mode write can land between two ticks
   always_ff @(posedge ref_clk_in) begin
      int_q <= clk_sel_out[0];
      if (rst_in) begin
         gap <= 1;
         steady <= 1'b0;
      end else if (engine_tick_out) begin
         gap <= 1;
         steady <= clk_sel_out[0] && int_q;
      end else begin
         gap <= gap + 1;
         if (!clk_sel_out[0]) steady <= 1'b0;
      end
   end
   // Saturating count of quiet cycles on the clock pin
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || $rose(ext_clk_in)) begin
         quiet <= 0;
      end else if (quiet < EXT_LOSS_CYCLES + 8) begin
         quiet <= quiet + 1;
      end
   end
   // Value one edge after a reset edge; the reset itself must not mask it
   property after_rst(v, e);
      disable iff (1'b0) rst_in |=> v == e;
   endproperty
   // Pin edge while the pin is forced as the timing source
   sequence ext_rise;
      clk_sel_out == 2'h0 ##0 $rose(ext_clk_in);
   endsequence
   cur_reset_a: assert property (after_rst(output9_current_code_out, 8'hAF))
      else $error("current code wrong after reset");
   dsel_reset_a: assert property (after_rst(variable_d_from_adc_out, 1'b0))
      else $error("variable source wrong after reset");
   autoinc_reset_a: assert property (after_rst(address_autoinc_enable_out, 1'b1))
      else $error("autoincrement wrong after reset");
   psave_reset_a: assert property (after_rst(power_save_enable_out, 1'b0))
      else $error("power save wrong after reset");
   pump_reset_a: assert property (after_rst(pump_gain_select_out, 2'h0))
      else $error("pump mode wrong after reset");
   clksel_reset_a: assert property (after_rst(clk_sel_out, 2'h0))
      else $error("clock select wrong after reset");
   ext_tick_a: assert property (ext_rise |-> ##[1:3] engine_tick_out)
      else $error("no tick after external edge");
   tick_pulse_a: assert property (engine_tick_out |=> !engine_tick_out)
      else $error("tick longer than one cycle");
   flag_mask_a: assert property (
      !clk_sel_out[1] [*2] |-> !ext_timing_in_use_flag_out)
      else $error("in-use flag set without detection");
   flag_int_a: assert property (
      (clk_sel_out == 2'h3) [*2] |-> !ext_timing_in_use_flag_out)
      else $error("in-use flag set on internal clock");
   int_pace_a: assert property (engine_tick_out && steady |-> gap == INT_DIV_CYCLES)
      else $error("internal tick spacing wrong");
   ext_loss_a: assert property (quiet > EXT_LOSS_CYCLES + 2 |-> !ext_timing_in_use_flag_out)
      else $error("in-use flag held without pin edges");
endmodule : misc_control_props
bind misc_control_and_output9_current_code misc_control_props #(
   .INT_DIV_CYCLES(INT_DIV_CYCLES),
   .EXT_LOSS_CYCLES(EXT_LOSS_CYCLES)
) props_i (.ref_clk_in, .rst_in, .ext_clk_in, .output9_current_code_out,
   .variable_d_from_adc_out, .address_autoinc_enable_out, .power_save_enable_out,
   .pump_gain_select_out, .clk_sel_out, .engine_tick_out, .ext_timing_in_use_flag_out);

// ### verification/tb_top.sv
// Self-checking bench for the misc control and output nine current registers
`timescale 1ns/1ps
module tb_top;
   localparam int DIV = 8;
   localparam int LOSS = 32;
   logic ref_clk_in, rst_in, scl_in, sda_low, ext_clk_in, sda_out, sda_oe_out;
   logic variable_d_from_adc_out, address_autoinc_enable_out, power_save_enable_out;
   logic pulse_width_low_power_enable_out, engine_tick_out, ext_timing_in_use_flag_out;
   logic [1:0] addr_sel_in, pump_gain_select_out, clk_sel_out;
   logic [7:0] output9_current_code_out;
   logic [6:0] dev;
   int m_cur, m_misc, tick_cnt, mismatches, cmp_count;
   // Open-drain wire with pull-up: low when either party pulls
   wire logic sda_in = ~(sda_low | (sda_oe_out & ~sda_out));
   misc_control_and_output9_current_code #(.INT_DIV_CYCLES(DIV), .EXT_LOSS_CYCLES(LOSS)) dut (
      .ref_clk_in, .rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .addr_sel_in,
      .ext_clk_in, .output9_current_code_out, .variable_d_from_adc_out,
      .address_autoinc_enable_out, .power_save_enable_out, .pump_gain_select_out,
      .pulse_width_low_power_enable_out, .clk_sel_out, .engine_tick_out,
      .ext_timing_in_use_flag_out);
   host_master host (.clk_in(ref_clk_in), .sda_wire_in(sda_in), .scl_out(scl_in),
      .sda_low_out(sda_low));
   initial begin
      ref_clk_in = 1'b0;
      forever #2 ref_clk_in = ~ref_clk_in;
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic chk_regs();
      chk("current", output9_current_code_out, 8'(m_cur));
      chk("var d", {7'h0, variable_d_from_adc_out}, 8'(m_misc[7]));
      chk("autoinc", {7'h0, address_autoinc_enable_out}, 8'(m_misc[6]));
      chk("psave", {7'h0, power_save_enable_out}, 8'(m_misc[5]));
      chk("pump", {6'h0, pump_gain_select_out}, 8'((m_misc >> 3) & 3));
      chk("pwm", {7'h0, pulse_width_low_power_enable_out}, 8'(m_misc[2]));
      chk("clksel", {6'h0, clk_sel_out}, 8'(m_misc & 3));
   endtask : chk_regs
   // Model mirrors the pointer: it moves only if autoincrement was on before the byte
   task automatic mwr(input logic [7:0] ofs, input logic [7:0] d0, input logic [7:0] d1,
      input int n);
      logic [7:0] p;
      logic ok;
      p = ofs;
      for (int k = 0; k < n; k++) begin
         logic inc;
         inc = m_misc[6];
         if (p == 8'h05) m_misc = (k == 0) ? d0 : d1;
         if (p == 8'h2E) m_cur = (k == 0) ? d0 : d1;
         if (inc) p++;
      end
      host.wr(dev, ofs, d0, d1, n, ok);
      chk("ack", {7'h0, ok}, 8'h01);
      chk_regs();
   endtask : mwr
   task automatic rchk(input logic [7:0] ofs, input int exp);
      logic [7:0] d;
      host.rd(dev, ofs, d);
      chk("readback", d, 8'(exp));
   endtask : rchk
   // Pin clock of n rising edges, counting ticks over a window of whole dividers
   task automatic run_ext(input int n, input int half);
      for (int k = 0; k < 2 * n * half + 8; k++) begin
         ext_clk_in <= (k < 2 * n * half) && ((k / half) % 2 == 0);
         @(posedge ref_clk_in);
         if (engine_tick_out === 1'b1) tick_cnt++;
      end
   endtask : run_ext
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run
   initial begin
      #(4 * 60000);
      mismatches++;
      complete_run();
   end
   initial begin
      logic [7:0] v;
      logic ok;
      logic [7:0] d;
      void'($urandom(32'hC6D3));
      rst_in = 1'b1;
      ext_clk_in = 1'b0;
      addr_sel_in = 2'($urandom);
      dev = {led_ctrl_pkg::DEV_ADDR_BASE[6:2], addr_sel_in};
      m_cur = 8'hAF;
      m_misc = 8'h40;
      repeat (20) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      chk_regs();
      rchk(8'h2E, 8'hAF);
      rchk(8'h05, 8'h40);
      $display("test reset values done");
      for (int i = 0; i < 3; i++) begin
         mwr(8'h2E, 8'($urandom), 8'h00, 1);
         rchk(8'h2E, m_cur);
      end
      v = 8'($urandom) | 8'h40;
      if (v[4]) v[2] = 1'b0;
      mwr(8'h05, v, 8'h00, 1);
      rchk(8'h05, m_misc);
      host.ph = 7;
      host.wr(dev ^ 7'h01, 8'h2E, 8'h00, 8'h00, 1, ok);
      chk("foreign ack", {7'h0, ok}, 8'h00);
      chk_regs();
      host.ph = 4;
      $display("test single writes done");
      mwr(8'h2D, 8'h11, 8'($urandom), 2);
      rchk(8'h2D, 8'h00);
      mwr(8'h05, 8'(m_misc) & 8'hBF, 8'h00, 1);
      mwr(8'h2E, 8'($urandom), 8'($urandom), 2);
      rchk(8'h2E, m_cur);
      mwr(8'h05, 8'h48, 8'h49, 2);
      $display("test burst pointer done");
      for (int m = 0; m < 4; m++) begin
         mwr(8'h05, 8'((m_misc & 8'hFC) | m), 8'h00, 1);
         tick_cnt = 0;
         fork
            run_ext(150, 2);
            host.rd(dev, 8'h3A, d);
         join
         chk("status", d, (m == 2) ? 8'h01 : 8'h00);
         chk("in use", {7'h0, ext_timing_in_use_flag_out}, 8'(m == 2));
         if (m != 2) chk("ticks", 8'(tick_cnt), 8'(m[0] ? 608 / DIV : 150));
         repeat (LOSS + 8) @(posedge ref_clk_in);
         chk("lost", {7'h0, ext_timing_in_use_flag_out}, 8'h00);
      end
      mwr(8'h05, 8'(m_misc & 8'hFC), 8'h00, 1);
      tick_cnt = 0;
      run_ext(40, 1);
      chk("fast ticks", 8'(tick_cnt), 8'd40);
      $display("test clock selection done");
      complete_run();
   end
endmodule : tb_top
